/* File: logic/scgcr_apb_if.sv */
// Purpose: APB slave front end of the congestion register bank.
// Assumes: One-cycle setup, zero wait states in the access phase.
// Notes: Produces one-cycle write and read strobes at the access edge.
`timescale 1ns/1ps
module scgcr_apb_if
  import scgcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  // Register side
  output logic wr_stb,
  output logic rd_stb,
  output logic [23:0] reg_idx,
  output logic [31:0] wr_data
);

  typedef struct packed {
    scgcr_bus_t st;
  } scgcr_apbst_t;

  scgcr_apbst_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    case (s_q.st)
      SCGCR_BUS_IDLE: begin
        if (psel && !penable) begin
          s_d.st = SCGCR_BUS_ACCESS;
        end
      end
      SCGCR_BUS_ACCESS: begin
        s_d.st = SCGCR_BUS_IDLE;
      end
      default: s_d.st = SCGCR_BUS_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      s_q <= '{st: SCGCR_BUS_IDLE};
    end else begin
      s_q <= s_d;
    end
  end

  // Zero wait states keep the register bank simple; every access answers at once.
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_stb = psel && penable && pwrite;
  assign rd_stb = psel && penable && !pwrite;
  assign reg_idx = paddr[25:2];
  assign wr_data = pwdata;

  pready_high_a: assert property (@(posedge mclk) disable iff (!rstn) psel && penable |-> pready)
    else $error("access phase without ready");

endmodule

/* File: logic/scgcr_group.sv */
// Purpose: One service class group: depth counter and congestion flags.
// Assumes: Enqueue and dequeue events come from the queue engine on mclk.
// Notes: Flags are registered from the depth after each update.
`timescale 1ns/1ps
module scgcr_group
  import scgcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Settings
  input wire scgcr_cfg_t cfg,
  input wire logic limit_en,
  input wire logic no_hyst,
  input wire logic alt_enc,
  // Depth events and software load
  input wire scgcr_qev_t qev,
  input wire logic depth_wr,
  input wire logic [14:0] depth_wdata,
  // Outputs
  output scgcr_state_t state,
  output logic refuse,
  output logic at_max_rise
);

  typedef struct packed {
    scgcr_state_t st;
  } scgcr_grpst_t;

  scgcr_grpst_t g_q, g_d;
  logic [15:0] cong_lvl, near_lvl, max_lvl, dep;
  logic [14:0] nd;

  always_comb begin
    g_d = g_q;
    dep = {1'b0, g_q.st.queue_depth};
    max_lvl = scgcr_code_depth(cfg.max_code, alt_enc);
    cong_lvl = scgcr_code_depth(cfg.cong_code, alt_enc);
    near_lvl = scgcr_code_depth(cfg.cong_code - ((cfg.cong_code != 4'h0) ? 4'h1 : 4'h0), alt_enc);
    nd = g_q.st.queue_depth;
    if (depth_wr) begin
      nd = depth_wdata;
    end else if (qev.inc && !qev.dec && !refuse && nd != 15'h7fff) begin
      nd = nd + 15'h0001;
    end else if (qev.dec && !qev.inc && nd != 15'h0000) begin
      nd = nd - 15'h0001;
    end
    g_d.st.queue_depth = nd; // RQ12 RQ17
    dep = {1'b0, nd};
    g_d.st.at_maximum = limit_en && (dep >= max_lvl); // RQ8
    g_d.st.near_congestion = dep > near_lvl; // RQ9
    g_d.st.over_threshold = dep > cong_lvl; // RQ10
    // Hysteresis holds congestion until depth falls to the level one code lower.
    if (no_hyst || !g_q.st.congested_flag) begin
      g_d.st.congested_flag = limit_en && (dep > cong_lvl); // RQ11
    end else begin
      g_d.st.congested_flag = limit_en && (dep > near_lvl); // RQ11
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      g_q <= '0; // RQ16
    end else begin
      g_q <= g_d;
    end
  end

  assign state = g_q.st;
  assign refuse = limit_en && g_q.st.at_maximum; // RQ3 RQ4
  assign at_max_rise = g_d.st.at_maximum && !g_q.st.at_maximum;

  no_limit_flags_a: assert property (@(posedge mclk) disable iff (!rstn)
    !limit_en ##1 !limit_en |-> !state.congested_flag && !state.at_maximum) // RQ3
    else $error("flag set with limits disabled");
  refused_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
    refuse && qev.inc && !qev.dec && !depth_wr |=> state.queue_depth == $past(state.queue_depth)) // RQ8
    else $error("depth grew past maximum");
  over_tracks_a: assert property (@(posedge mclk) disable iff (!rstn)
    ##1 state.over_threshold == ({1'b0, state.queue_depth} > scgcr_code_depth(cfg.cong_code, alt_enc))
    || $changed(cfg) || $changed(alt_enc)) // RQ10
    else $error("over threshold flag wrong");
  near_implied_a: assert property (@(posedge mclk) disable iff (!rstn)
    state.over_threshold && $stable(cfg) && $stable(alt_enc) |-> state.near_congestion) // RQ9
    else $error("near flag missing");
  depth_load_a: assert property (@(posedge mclk) disable iff (!rstn)
    depth_wr |=> state.queue_depth == $past(depth_wdata)) // RQ12
    else $error("depth load lost");

endmodule

/* File: logic/scgcr_pkg.sv */
// Purpose: Shared constants and types for the service class group congestion register bank.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Printed offsets are word indices; byte address is four times the index.
package scgcr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [23:0] SCGCR_IDX_RX32_CFG = 24'h1f0016;
  localparam logic [23:0] SCGCR_IDX_RX32_ST = 24'h1f0017;
  localparam logic [23:0] SCGCR_IDX_RX48_CFG = 24'h1f0018;
  localparam logic [23:0] SCGCR_IDX_RX48_ST = 24'h1f0019;
  localparam logic [23:0] SCGCR_IDX_TX4_CFG = 24'h1f001a;
  localparam logic [23:0] SCGCR_IDX_TX4_ST = 24'h1f001b;
  localparam logic [23:0] SCGCR_IDX_CTRL = 24'h1f0030;
  localparam logic [23:0] SCGCR_IDX_IRQ_ST = 24'h1f0031;
  localparam logic [23:0] SCGCR_IDX_IRQ_MASK = 24'h1f0032;

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int SCGCR_MAX_LSB = 12;
  localparam int SCGCR_CONG_LSB = 8;
  localparam int SCGCR_AT_MAX_BIT = 19;
  localparam int SCGCR_NEAR_BIT = 18;
  localparam int SCGCR_OVER_BIT = 17;
  localparam int SCGCR_CONGESTED_BIT = 16;
  localparam int SCGCR_RSVD_BIT = 15;
  localparam int SCGCR_DEPTH_W = 15;
  localparam int SCGCR_CTRL_RX_EN = 0;
  localparam int SCGCR_CTRL_TX_EN = 1;
  localparam int SCGCR_CTRL_RX_NOHYS = 2;
  localparam int SCGCR_CTRL_TX_NOHYS = 3;
  localparam int SCGCR_CTRL_RX_ALT = 4;
  localparam int SCGCR_CTRL_TX_ALT = 5;
  localparam int SCGCR_CTRL_SWRST = 6;
  localparam logic [3:0] SCGCR_CODE_RST = 4'h0;
  localparam logic [14:0] SCGCR_DEPTH_RST = 15'h0000;
  localparam logic [6:0] SCGCR_CTRL_RST = 7'h00;
  localparam int SCGCR_NGRP = 3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [3:0] max_code;
    logic [3:0] cong_code;
  } scgcr_cfg_t;

  typedef struct packed {
    logic at_maximum;
    logic near_congestion;
    logic over_threshold;
    logic congested_flag;
    logic [14:0] queue_depth;
  } scgcr_state_t;

  typedef struct packed {
    logic inc;
    logic dec;
  } scgcr_qev_t;

  typedef enum logic [1:0] {
    SCGCR_BUS_IDLE = 2'b00,
    SCGCR_BUS_ACCESS = 2'b01
  } scgcr_bus_t;

  // Depth threshold from a 4-bit code: exponent form is 2^code, alternate form is 3*2^(code-1).
  function automatic logic [15:0] scgcr_code_depth(input logic [3:0] code, input logic alt);
    logic [15:0] p;
    p = 16'h0001 << code;
    if (alt && code != 4'h0) begin
      scgcr_code_depth = p | (p >> 1);
    end else begin
      scgcr_code_depth = p;
    end
  endfunction

  // Service class membership of each group: 0 rx lower 32, 1 rx lower 48, 2 tx lower 4.
  function automatic logic scgcr_member(input int grp, input logic [5:0] sc);
    case (grp)
      0: scgcr_member = (sc[4] == 1'b1);
      1: scgcr_member = (sc[4:3] != 2'b00);
      2: scgcr_member = (sc[2:1] == 2'b11) && (sc[5:4] == 2'b00);
      default: scgcr_member = 1'b0;
    endcase
  endfunction

endpackage

/* File: logic/scgcr_top.sv */
// Purpose: Congestion register bank for three service class groups on APB.
// Assumes: mclk 100 MHz, rstn synchronous active low, queue engine on mclk.
// Notes: Control and interrupt words sit at locally chosen indices.
//
// Function
// RQ1 - Config bits 15:12 hold the group maximum depth code.
// RQ2 - Config bits 11:8 hold the group congestion depth code.
// RQ3 - Receive group limits act only while receive limit enable is one.
// RQ4 - Transmit group limits act only while transmit limit enable is one.
// RQ5 - Receive lower 32 group counts classes 16-31 and 48-63.
// RQ6 - Receive lower 48 group counts classes 8-31 and 40-63.
// RQ7 - Transmit lower 4 group counts classes 6-7 and 14-15.
// RQ8 - State bit 19 shows maximum congestion, read only, resets zero.
// RQ9 - State bit 18 shows depth above the level one code below congestion.
// RQ10 - State bit 17 shows depth above the congestion code level.
// RQ11 - State bit 16 congestion from code, hysteresis and encoding settings.
// RQ12 - State bits 14:0 give the 15-bit current depth, reset zero.
// RQ13 - Software zeroes the depth field whenever it asserts software reset.
// RQ14 - Software writes zero to state bit 15 during software reset.
// RQ15 - Software writes zeros to all unused config and state bits.
// RQ16 - All config and state registers reset to zero.
// RQ17 - Depth and flags follow enqueues and dequeues of member classes.
`timescale 1ns/1ps
module scgcr_top
  import scgcr_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receive queue engine events
  input wire logic rx_enq,
  input wire logic rx_deq,
  input wire logic [5:0] rx_class,
  // Transmit queue engine events
  input wire logic tx_enq,
  input wire logic tx_deq,
  input wire logic [5:0] tx_class,
  // Admission answers
  output logic rx_refuse,
  output logic tx_refuse,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  logic wr_stb, rd_stb;
  logic [23:0] reg_idx;
  logic [31:0] wr_data;

  scgcr_apb_if u_apb (
    .mclk(mclk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb),
    .rd_stb(rd_stb),
    .reg_idx(reg_idx),
    .wr_data(wr_data)
  );

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  typedef struct packed {
    scgcr_cfg_t [SCGCR_NGRP-1:0] cfg;
    logic [6:0] ctrl;
    logic [SCGCR_NGRP-1:0] irq_st;
    logic [SCGCR_NGRP-1:0] irq_mask;
    logic [31:0] rdata;
  } scgcr_regs_t;

  scgcr_regs_t r_q, r_d;

  scgcr_state_t [SCGCR_NGRP-1:0] gst;
  logic [SCGCR_NGRP-1:0] grefuse, grise, dwr;
  scgcr_qev_t [SCGCR_NGRP-1:0] qev;
  logic [SCGCR_NGRP-1:0] gen, gnohys, galt;

  function automatic logic [23:0] scgcr_cfg_idx(input int g);
    case (g)
      0: scgcr_cfg_idx = SCGCR_IDX_RX32_CFG;
      1: scgcr_cfg_idx = SCGCR_IDX_RX48_CFG;
      default: scgcr_cfg_idx = SCGCR_IDX_TX4_CFG;
    endcase
  endfunction

  function automatic logic [23:0] scgcr_st_idx(input int g);
    case (g)
      0: scgcr_st_idx = SCGCR_IDX_RX32_ST;
      1: scgcr_st_idx = SCGCR_IDX_RX48_ST;
      default: scgcr_st_idx = SCGCR_IDX_TX4_ST;
    endcase
  endfunction

  // ----------------------------------------
  // Groups
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < SCGCR_NGRP; gi++) begin : g_grp
      if (gi < 2) begin : g_rx
        assign gen[gi] = r_q.ctrl[SCGCR_CTRL_RX_EN]; // RQ3
        assign gnohys[gi] = r_q.ctrl[SCGCR_CTRL_RX_NOHYS];
        assign galt[gi] = r_q.ctrl[SCGCR_CTRL_RX_ALT];
        assign qev[gi].inc = rx_enq && scgcr_member(gi, rx_class); // RQ5 RQ6
        assign qev[gi].dec = rx_deq && scgcr_member(gi, rx_class); // RQ5 RQ6
      end else begin : g_tx
        assign gen[gi] = r_q.ctrl[SCGCR_CTRL_TX_EN]; // RQ4
        assign gnohys[gi] = r_q.ctrl[SCGCR_CTRL_TX_NOHYS];
        assign galt[gi] = r_q.ctrl[SCGCR_CTRL_TX_ALT];
        assign qev[gi].inc = tx_enq && scgcr_member(gi, tx_class); // RQ7
        assign qev[gi].dec = tx_deq && scgcr_member(gi, tx_class); // RQ7
      end
      assign dwr[gi] = wr_stb && reg_idx == scgcr_st_idx(gi);
      scgcr_group u_grp (
        .mclk(mclk),
        .rstn(rstn),
        .cfg(r_q.cfg[gi]),
        .limit_en(gen[gi]),
        .no_hyst(gnohys[gi]),
        .alt_enc(galt[gi]),
        .qev(qev[gi]),
        .depth_wr(dwr[gi]),
        .depth_wdata(wr_data[SCGCR_DEPTH_W-1:0]),
        .state(gst[gi]),
        .refuse(grefuse[gi]),
        .at_max_rise(grise[gi])
      );
    end
  endgenerate

  // A receive cell is refused when any group that holds its class is full.
  assign rx_refuse = (grefuse[0] && scgcr_member(0, rx_class)) || (grefuse[1] && scgcr_member(1, rx_class));
  assign tx_refuse = grefuse[2] && scgcr_member(2, tx_class);

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always_comb begin
    r_d = r_q;
    // Set wins over a write-one clear in the same cycle.
    if (wr_stb && reg_idx == SCGCR_IDX_IRQ_ST) begin
      r_d.irq_st = r_q.irq_st & ~wr_data[SCGCR_NGRP-1:0];
    end
    r_d.irq_st = r_d.irq_st | grise;
    if (wr_stb) begin
      for (int g = 0; g < SCGCR_NGRP; g++) begin
        if (reg_idx == scgcr_cfg_idx(g)) begin
          r_d.cfg[g].max_code = wr_data[SCGCR_MAX_LSB +: 4]; // RQ1
          r_d.cfg[g].cong_code = wr_data[SCGCR_CONG_LSB +: 4]; // RQ2
        end
      end
      if (reg_idx == SCGCR_IDX_CTRL) begin
        r_d.ctrl = wr_data[6:0];
      end
      if (reg_idx == SCGCR_IDX_IRQ_MASK) begin
        r_d.irq_mask = wr_data[SCGCR_NGRP-1:0];
      end
    end
    if (rd_stb) begin
      r_d.rdata = 32'h0000_0000;
      for (int g = 0; g < SCGCR_NGRP; g++) begin
        if (reg_idx == scgcr_cfg_idx(g)) begin
          r_d.rdata = {16'h0000, r_q.cfg[g], 8'h00};
        end
        if (reg_idx == scgcr_st_idx(g)) begin
          r_d.rdata = {12'h000, gst[g][18:15], 1'b0, gst[g].queue_depth}; // RQ8 RQ12
        end
      end
      if (reg_idx == SCGCR_IDX_CTRL) begin
        r_d.rdata = {25'h0000000, r_q.ctrl};
      end
      if (reg_idx == SCGCR_IDX_IRQ_ST) begin
        r_d.rdata = {29'h00000000, r_q.irq_st};
      end
      if (reg_idx == SCGCR_IDX_IRQ_MASK) begin
        r_d.rdata = {29'h00000000, r_q.irq_mask};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      r_q <= '0; // RQ16
    end else begin
      r_q <= r_d;
    end
  end

  // Read data comes straight from the next-state copy, so it stands during the access cycle.
  assign prdata = r_d.rdata;
  assign irq = |(r_q.irq_st & r_q.irq_mask);

  cfg_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    wr_stb && reg_idx == SCGCR_IDX_RX32_CFG |=> r_q.cfg[0].max_code == $past(wr_data[15:12])) // RQ1
    else $error("max code not stored");
  cong_write_a: assert property (@(posedge mclk) disable iff (!rstn)
    wr_stb && reg_idx == SCGCR_IDX_TX4_CFG |=> r_q.cfg[2].cong_code == $past(wr_data[11:8])) // RQ2
    else $error("congestion code not stored");
  tx_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
    !r_q.ctrl[SCGCR_CTRL_TX_EN] |-> !tx_refuse) // RQ4
    else $error("transmit refused while disabled");
  rx32_member_a: assert property (@(posedge mclk) disable iff (!rstn)
    rx_class == 6'h2f |-> !qev[0].inc && qev[1].inc == rx_enq) // RQ5
    else $error("class 47 membership wrong");
  rx48_member_a: assert property (@(posedge mclk) disable iff (!rstn)
    rx_class == 6'h08 |-> !qev[0].inc && qev[1].inc == rx_enq) // RQ6
    else $error("class 8 membership wrong");
  tx4_member_a: assert property (@(posedge mclk) disable iff (!rstn)
    tx_class == 6'h05 |-> !qev[2].inc) // RQ7
    else $error("class 5 in transmit group");
  irq_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
    grise[0] |=> r_q.irq_st[0]) // RQ17
    else $error("event lost");
  reset_zero_a: assert property (@(posedge mclk)
    !rstn |=> r_q.ctrl == 7'h00 && gst[0].queue_depth == 15'h0000) // RQ16
    else $error("not zero after reset");

endmodule

/* File: sim/scgcr_top_tb.sv */
// Purpose: Self-checking bench for the congestion register bank over APB.
// Assumes: Zero wait state slave, queue events as one-cycle pulses.
// Notes: The bench keeps its own depth and flag model for each group.
`timescale 1ns/1ps
module scgcr_top_tb
  import scgcr_pkg::*;
;
  // ----------------------------------------
  // Signals and model state
  // ----------------------------------------
  logic mclk;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_enq;
  logic rx_deq;
  logic tx_enq;
  logic tx_deq;
  logic [5:0] rx_class;
  logic [5:0] tx_class;
  logic rx_refuse;
  logic tx_refuse;
  logic irq;
  logic [31:0] rdata;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int d[3];
  int mx[3];
  int cg[3];
  bit en[3];
  bit nh[3];
  bit al[3];
  bit cf[3];
  logic [23:0] cfg_idx[3] = '{SCGCR_IDX_RX32_CFG, SCGCR_IDX_RX48_CFG, SCGCR_IDX_TX4_CFG};
  logic [23:0] st_idx[3] = '{SCGCR_IDX_RX32_ST, SCGCR_IDX_RX48_ST, SCGCR_IDX_TX4_ST};

  scgcr_top u_scgcr_top (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_enq(rx_enq), .rx_deq(rx_deq), .rx_class(rx_class),
    .tx_enq(tx_enq), .tx_deq(tx_deq), .tx_class(tx_class),
    .rx_refuse(rx_refuse), .tx_refuse(tx_refuse), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // The run should need about 1050 cycles; the ceiling leaves ample margin.
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Ends with an idle cycle so that psel is never driven twice in one step.
  task automatic apb(input logic w, input logic [23:0] idx, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {6'h00, idx, 2'b00};
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) begin
      @(posedge mclk);
    end
    rdata = prdata;
    chk("pslverr", 32'h0, {31'h0, pslverr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdchk(input string nm, input logic [23:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h00000000);
    chk(nm, exp, rdata);
  endtask

  // ----------------------------------------
  // Group model
  // ----------------------------------------
  function automatic int lvl(input int c, input bit a);
    if (c < 0) begin
      return 1;
    end
    if (c == 0) begin
      return 1;
    end
    return (1 << c) + (a ? (1 << (c - 1)) : 0);
  endfunction

  function automatic logic [31:0] exp_st(input int g);
    return {12'h000, en[g] && d[g] >= lvl(mx[g], al[g]), d[g] > lvl(cg[g] - 1, al[g]),
            d[g] > lvl(cg[g], al[g]), cf[g], 1'b0, 15'(d[g])};
  endfunction

  function automatic void upd(input int g);
    bit over;
    over = en[g] && d[g] > lvl(cg[g], al[g]);
    if (nh[g] || over) begin
      cf[g] = over;
    end else if (d[g] <= lvl(cg[g] - 1, al[g])) begin
      cf[g] = 1'b0;
    end
  endfunction

  function automatic bit mem(input int g, input int c);
    case (g)
      0: return (c >= 16 && c <= 31) || c >= 48;
      1: return (c >= 8 && c <= 31) || c >= 40;
      default: return c inside {6, 7, 14, 15};
    endcase
  endfunction

  task automatic chk_all();
    for (int g = 0; g < 3; g++) begin
      rdchk("group state", st_idx[g], exp_st(g));
    end
  endtask

  task automatic set_cfg(input int g, input int m, input int k);
    apb(1'b1, cfg_idx[g], {16'h0000, 4'(m), 4'(k), 8'h00});
    mx[g] = m;
    cg[g] = k;
    rdchk("config", cfg_idx[g], {16'h0000, 4'(m), 4'(k), 8'h00});
  endtask

  // One queue event of each direction at one edge; both directions use class c.
  task automatic ev(input bit re, input bit rdq, input bit te, input bit tdq, input int c);
    bit refuse[2];
    bit e;
    bit q;
    refuse = '{1'b0, 1'b0};
    rx_enq <= re;
    rx_deq <= rdq;
    tx_enq <= te;
    tx_deq <= tdq;
    rx_class <= 6'(c);
    tx_class <= 6'(c);
    for (int g = 0; g < 3; g++) begin
      if (mem(g, c) && en[g] && d[g] >= lvl(mx[g], al[g])) begin
        refuse[g / 2] = 1'b1;
      end
    end
    @(posedge mclk);
    if (re) chk("rx_refuse", {31'h0, refuse[0]}, {31'h0, rx_refuse});
    if (te) chk("tx_refuse", {31'h0, refuse[1]}, {31'h0, tx_refuse});
    for (int g = 0; g < 3; g++) begin
      e = (g < 2) ? re : te;
      q = (g < 2) ? rdq : tdq;
      if (mem(g, c)) begin
        if (e && !q && !(en[g] && d[g] >= lvl(mx[g], al[g]))) d[g]++;
        if (q && !e && d[g] > 0) d[g]--;
        upd(g);
      end
    end
    rx_enq <= 1'b0;
    rx_deq <= 1'b0;
    tx_enq <= 1'b0;
    tx_deq <= 1'b0;
    @(posedge mclk);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h00000000;
    pwdata = 32'h00000000;
    {rx_enq, rx_deq, tx_enq, tx_deq} = 4'h0;
    rx_class = 6'h00;
    tx_class = 6'h00;
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    for (int g = 0; g < 3; g++) begin
      rdchk("config reset", cfg_idx[g], 32'h00000000);
      rdchk("state reset", st_idx[g], 32'h00000000);
    end
    apb(1'b1, 24'h1f0020, 32'hffffffff);
    rdchk("unmapped", 24'h1f0020, 32'h00000000);
    // Limits are off here, so a zero maximum code must not stop any group growing.
    for (int c = 0; c < 64; c++) begin
      ev(1'b1, 1'b0, 1'b1, 1'b0, c);
      chk_all();
    end
    for (int g = 0; g < 3; g++) begin
      apb(1'b1, st_idx[g], 32'h00000000);
      d[g] = 0;
      upd(g);
    end
    chk_all();
    set_cfg(0, 3, 2);
    set_cfg(1, 15, 15);
    set_cfg(2, 2, 1);
    // Receive: limits on, no hysteresis, alternate codes; transmit: limits on, hysteresis.
    apb(1'b1, SCGCR_IDX_CTRL, 32'h00000017);
    rdchk("control", SCGCR_IDX_CTRL, 32'h00000017);
    en = '{1'b1, 1'b1, 1'b1};
    nh = '{1'b1, 1'b1, 1'b0};
    al = '{1'b1, 1'b1, 1'b0};
    repeat (13) begin
      ev(1'b1, 1'b0, 1'b0, 1'b0, 16);
      chk_all();
    end
    rdchk("irq status", SCGCR_IDX_IRQ_ST, 32'h00000001);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, SCGCR_IDX_IRQ_MASK, 32'h00000001);
    @(posedge mclk);
    chk("irq unmasked", 32'h1, {31'h0, irq});
    apb(1'b1, SCGCR_IDX_IRQ_ST, 32'h00000001);
    rdchk("irq cleared", SCGCR_IDX_IRQ_ST, 32'h00000000);
    chk("irq low", 32'h0, {31'h0, irq});
    repeat (5) begin
      ev(1'b0, 1'b0, 1'b1, 1'b0, 7);
      chk_all();
    end
    // Draining shows the congestion flag held until depth falls to the lower level.
    repeat (4) begin
      ev(1'b0, 1'b0, 1'b0, 1'b1, 7);
      chk_all();
    end
    rdchk("irq status", SCGCR_IDX_IRQ_ST, 32'h00000004);
    chk("irq masked", 32'h0, {31'h0, irq});
    close_out();
  end
endmodule
